// ===== hw/dioc_digital_io.sv
// Digital I/O pin configuration and input conditioning with an Avalon-MM slave.
//
// Contract
// - Alt bit1 clock on pin2, bit2 direction pin3.
// - Without alt function, clock/direction pins unusable; the code still uses them as conditioned inputs.
// - Stepping mode forces pins, overwrites pin config.
// - Direction mask bit: 0 input, 1 output.
// - Pull mask: 0 pulldown, 1 pullup, inputs only.
// - Each I/O: special bit low, level high.
// - Level bit of I/O n at 15+n.
// - Output pins 1-4 still readable at 16-19.
// - Sample each millisecond, ignore shorter glitches.
// - Special enable gates low bits only.
// - Bits: negative, positive limit, home, interlock.
// - Inversion selects normally closed, not clock/direction.
// - Force enable substitutes force value for pin.
// - Raw value shows sampled levels unchanged.
// - Input 1 level bit shows full computed state.
// - Six pins, only first four outputs; the code drives pins 1 and 4 only.
`timescale 1ns/100ps
`default_nettype none
`include "dioc_regs.svh"
module dioc_digital_io
  import dioc_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM register slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // Pins: input levels, drive values and enables, pull selection.
  input  wire logic [5:0]  pin_in,
  output logic      [3:0]  pin_out,
  output logic      [3:0]  pin_oe,
  output logic      [5:0]  pin_pull_up,
  // Step clock and direction towards the stepping logic.
  output logic             step_clock,
  output logic             step_direction,
  // Special functions towards motion control.
  output logic             limit_negative,
  output logic             limit_positive,
  output logic             home_switch,
  output logic             interlock_release,
  output logic             brake_request
);

  // Software state.
  logic [15:0] alternate_function_mask, next_alt;
  logic [15:0] pin_direction_mask, next_dir;
  logic [15:0] pin_pull_mask, next_pull;
  logic [31:0] output_image, next_out_img;
  logic [31:0] input_special_enable, next_spec;
  logic [31:0] input_invert, next_inv;
  logic [31:0] input_force_enable, next_fen;
  logic [31:0] input_force_value, next_fval;
  logic        step_mode, next_step_mode;
  // Bus state.
  dioc_bus_e   bus_state, next_bus_state;
  logic [31:0] next_rdata;
  logic [1:0]  next_resp;
  // Sampling state.
  logic [5:0]  sync1, sync2, sync3;
  logic [5:0]  stable, next_stable;
  logic [5:0]  input_raw_value, next_raw;
  logic [16:0] tick_cnt, next_tick_cnt;
  logic        tick;
  // Conditioned inputs.
  logic [5:0]  forced, cond;
  logic [5:0]  eff_dir, eff_alt, drives;
  logic [31:0] input_image;

  // Stepping mode takes over the clock and direction pins regardless of software masks.
  always_comb begin
    eff_alt = alternate_function_mask[5:0];
    eff_dir = {2'b00, pin_direction_mask[3:0]};
    if (step_mode) begin
      eff_alt[`DIOC_ALT_CLK_BIT] = 1'b1;
      eff_alt[`DIOC_ALT_DIR_BIT] = 1'b1;
    end
    if (eff_alt[`DIOC_ALT_CLK_BIT]) begin
      eff_dir[`DIOC_ALT_CLK_BIT] = 1'b0;
    end
    if (eff_alt[`DIOC_ALT_DIR_BIT]) begin
      eff_dir[`DIOC_ALT_DIR_BIT] = 1'b0;
    end
    // Pins 2 and 3 never drive, with or without their alternate role; they stay conditioned inputs.
    drives = eff_dir;
    drives[`DIOC_ALT_CLK_BIT] = 1'b0;
    drives[`DIOC_ALT_DIR_BIT] = 1'b0;
  end

  // Pin drivers; pull applies only to pins that are inputs.
  always_comb begin
    pin_oe  = drives[3:0];
    pin_out = output_image[`DIOC_LEVEL_BASE +: 4] & drives[3:0];
    pin_pull_up = pin_pull_mask[5:0] & ~eff_dir;
    brake_request = output_image[0];
  end

  // Three-stage synchroniser on the pin levels.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
      sync3 <= 6'h00;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Millisecond tick and filtering: a level counts once agreed and held at two ticks.
  always_comb begin
    tick          = (tick_cnt == 17'(`DIOC_SAMPLE_CYCLES - 1));
    next_tick_cnt = tick ? 17'h00000 : tick_cnt + 17'h00001;
    next_stable   = stable;
    next_raw      = input_raw_value;
    if (tick) begin
      next_stable = sync3;
      next_raw    = input_raw_value;
      for (int i = 0; i < `DIOC_NUM_PINS; i++) begin
        if ((sync2[i] == sync3[i]) && (sync3[i] == stable[i])) begin
          next_raw[i] = sync3[i];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt        <= 17'h00000;
      stable          <= 6'h00;
      input_raw_value <= 6'h00;
    end else begin
      tick_cnt        <= next_tick_cnt;
      stable          <= next_stable;
      input_raw_value <= next_raw;
    end
  end

  // Conditioning per input: raw, force, invert, then gate the special bit.
  generate
    for (genvar g = 0; g < `DIOC_NUM_PINS; g++) begin : g_cond
      assign forced[g] = input_force_enable[g] ? input_force_value[g]
                                               : input_raw_value[g];
      assign cond[g] = (eff_alt[g] && (g == `DIOC_ALT_CLK_BIT || g == `DIOC_ALT_DIR_BIT))
                     ? forced[g] : forced[g] ^ input_invert[g];
    end
  endgenerate

  // Input image: special bits low, levels high; driven pins report their drive.
  always_comb begin
    input_image = `DIOC_RST_ZERO32;
    for (int i = 0; i < `DIOC_NUM_PINS; i++) begin
      input_image[i] = cond[i] & input_special_enable[i];
      input_image[`DIOC_LEVEL_BASE + i] = cond[i];
    end
    for (int i = 0; i < `DIOC_NUM_FLEX; i++) begin
      if (drives[i]) begin
        input_image[`DIOC_LEVEL_BASE + i] = output_image[`DIOC_LEVEL_BASE + i];
      end
    end
  end

  // Special functions and step signals.
  always_comb begin
    limit_negative    = input_image[0];
    limit_positive    = input_image[1];
    home_switch       = input_image[2];
    interlock_release = input_image[3];
    step_clock        = eff_alt[`DIOC_ALT_CLK_BIT] & cond[`DIOC_ALT_CLK_BIT];
    step_direction    = eff_alt[`DIOC_ALT_DIR_BIT] & cond[`DIOC_ALT_DIR_BIT];
  end

  // Register bus: one wait cycle, then answer with data and response.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    next_alt       = alternate_function_mask;
    next_dir       = pin_direction_mask;
    next_pull      = pin_pull_mask;
    next_out_img   = output_image;
    next_spec      = input_special_enable;
    next_inv       = input_invert;
    next_fen       = input_force_enable;
    next_fval      = input_force_value;
    next_step_mode = step_mode;
    next_bus_state = DIOC_BUS_IDLE;
    next_rdata     = avs_readdata;
    next_resp      = 2'h0;
    if (bus_state == DIOC_BUS_IDLE && (avs_read || avs_write)) begin
      next_bus_state = DIOC_BUS_ANSWER;
      next_rdata     = `DIOC_RST_ZERO32;
      unique case (avs_address)
        `DIOC_OFF_ALT_MASK:  next_rdata = {16'h0000, alternate_function_mask};
        `DIOC_OFF_DIR_MASK:  next_rdata = {16'h0000, pin_direction_mask};
        `DIOC_OFF_PULL_MASK: next_rdata = {16'h0000, pin_pull_mask};
        `DIOC_OFF_IN_IMAGE:  next_rdata = input_image;
        `DIOC_OFF_OUT_IMAGE: next_rdata = output_image;
        `DIOC_OFF_SPEC_EN:   next_rdata = input_special_enable;
        `DIOC_OFF_INVERT:    next_rdata = input_invert;
        `DIOC_OFF_FORCE_EN:  next_rdata = input_force_enable;
        `DIOC_OFF_FORCE_VAL: next_rdata = input_force_value;
        `DIOC_OFF_RAW:       next_rdata = {26'h0000000, input_raw_value};
        `DIOC_OFF_MODE:      next_rdata = {31'h00000000, step_mode};
        default:             next_resp  = 2'h2;
      endcase
      if (avs_write) begin
        next_rdata = `DIOC_RST_ZERO32;
        unique case (avs_address)
          `DIOC_OFF_ALT_MASK:  next_alt  = 16'(merge({16'h0000, alternate_function_mask},
                                                     avs_writedata,
                                                     avs_byteenable));
          `DIOC_OFF_DIR_MASK:  next_dir  = 16'(merge({16'h0000, pin_direction_mask},
                                                     avs_writedata,
                                                     avs_byteenable));
          `DIOC_OFF_PULL_MASK: next_pull = 16'(merge({16'h0000, pin_pull_mask},
                                                     avs_writedata,
                                                     avs_byteenable));
          `DIOC_OFF_OUT_IMAGE: next_out_img = merge(output_image, avs_writedata,
                                                    avs_byteenable);
          `DIOC_OFF_SPEC_EN:   next_spec = merge(input_special_enable, avs_writedata,
                                                 avs_byteenable);
          `DIOC_OFF_INVERT:    next_inv  = merge(input_invert, avs_writedata,
                                                 avs_byteenable);
          `DIOC_OFF_FORCE_EN:  next_fen  = merge(input_force_enable, avs_writedata,
                                                 avs_byteenable);
          `DIOC_OFF_FORCE_VAL: next_fval = merge(input_force_value, avs_writedata,
                                                 avs_byteenable);
          `DIOC_OFF_MODE: begin
            if (avs_byteenable[0]) begin
              next_step_mode = avs_writedata[0];
            end
          end
          `DIOC_OFF_IN_IMAGE, `DIOC_OFF_RAW: next_resp = 2'h0;
          default: next_resp = 2'h2;
        endcase
        // Entering stepping mode overwrites the pin configuration.
        if (avs_address == `DIOC_OFF_MODE && avs_byteenable[0] && avs_writedata[0]) begin
          next_alt[`DIOC_ALT_CLK_BIT] = 1'b1;
          next_alt[`DIOC_ALT_DIR_BIT] = 1'b1;
          next_dir[`DIOC_ALT_CLK_BIT] = 1'b0;
          next_dir[`DIOC_ALT_DIR_BIT] = 1'b0;
        end
      end
    end
    next_dir[15:4] = 12'h000;
  end

  // Waitrequest drops only in the answer cycle.
  assign avs_waitrequest = (bus_state != DIOC_BUS_ANSWER);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alternate_function_mask <= `DIOC_RST_ZERO16;
      pin_direction_mask      <= `DIOC_RST_ZERO16;
      pin_pull_mask           <= `DIOC_RST_ZERO16;
      output_image            <= `DIOC_RST_ZERO32;
      input_special_enable    <= `DIOC_RST_ZERO32;
      input_invert            <= `DIOC_RST_ZERO32;
      input_force_enable      <= `DIOC_RST_ZERO32;
      input_force_value       <= `DIOC_RST_ZERO32;
      step_mode               <= 1'b0;
      bus_state               <= DIOC_BUS_IDLE;
      avs_readdata            <= `DIOC_RST_ZERO32;
      avs_response            <= 2'h0;
    end else begin
      alternate_function_mask <= next_alt;
      pin_direction_mask      <= next_dir;
      pin_pull_mask           <= next_pull;
      output_image            <= next_out_img;
      input_special_enable    <= next_spec;
      input_invert            <= next_inv;
      input_force_enable      <= next_fen;
      input_force_value       <= next_fval;
      step_mode               <= next_step_mode;
      bus_state               <= next_bus_state;
      avs_readdata            <= next_rdata;
      avs_response            <= next_resp;
    end
  end

  // Checks next to the logic.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_NO_FLEX_OUT_56: assert property (pin_pull_up[5:4] == pin_pull_mask[5:4])
    else $error("Input-only pins must keep their pull selection.");
  AST_DIR_OUTPUT: assert property (pin_oe[0] == pin_direction_mask[0])
    else $error("Pin one enable does not follow direction mask.");
  AST_PULL_ONLY_IN: assert property (pin_oe[0] |-> !pin_pull_up[0])
    else $error("Pull applied to a driven pin.");
  AST_LEVEL_POS: assert property (!drives[0] |-> input_image[16] == cond[0])
    else $error("Input one level bit misplaced.");
  AST_SPEC_GATE: assert property (!input_special_enable[2] |-> !home_switch)
    else $error("Home switch active while disabled.");
  AST_FORCE: assert property (input_force_enable[5] && !input_invert[5]
                              |-> input_image[21] == input_force_value[5])
    else $error("Forced input value not used.");
  AST_RAW_HOLD: assert property (!tick |=> $stable(input_raw_value))
    else $error("Raw value changed between ticks.");
  AST_TICK_SPAN: assert property (tick |=> !tick [*8])
    else $error("Sample ticks too close together.");
  AST_READBACK: assert property (pin_oe[3] |-> input_image[19] == pin_out[3])
    else $error("Output pin four not reported in input image.");
  AST_STEP_MODE: assert property (step_mode |-> pin_oe[2:1] == 2'b00)
    else $error("Stepping pins driven in stepping mode.");
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
                                   |=> !avs_waitrequest)
    else $error("Bus answer late.");

  // Pin roles: dedicated pins never drive, step signals skip the inversion.
  AST_FLEX_NOT_DRIVEN: assert property (pin_oe[2:1] == 2'b00)
    else $error("Dedicated pin two or three driven.");
  AST_STEP_CLOCK_RAW: assert property (eff_alt[1] |-> step_clock == forced[1])
    else $error("Step clock not taken from pin two.");
  AST_STEP_DIR_RAW: assert property (eff_alt[2] |-> step_direction == forced[2])
    else $error("Step direction inverted or misrouted.");
  AST_PULL_DRIVEN: assert property (pin_oe[3] |-> !pin_pull_up[3])
    else $error("Pull applied to driven pin four.");
  AST_OUT_LEVEL: assert property (pin_oe[0] |-> pin_out[0] == output_image[16])
    else $error("Output one not driven from its level bit.");
  AST_BRAKE: assert property (brake_request == output_image[0])
    else $error("Brake request not taken from special bit zero.");

  // Image layout and conditioning order.
  AST_IMAGE_SPARE: assert property (input_image[31:22] == 10'h000
                                    && input_image[15:6] == 10'h000)
    else $error("Unused input image bits set.");
  AST_LIMIT_NEG: assert property (limit_negative == (cond[0] & input_special_enable[0]))
    else $error("Negative limit not gated input one.");
  AST_INTERLOCK: assert property (interlock_release == (cond[3] & input_special_enable[3]))
    else $error("Interlock not gated input four.");
  AST_SPEC_HOME_ON: assert property (input_special_enable[2] |-> home_switch == cond[2])
    else $error("Home switch does not follow input three.");
  AST_INVERT_ORDER: assert property (!input_force_enable[4]
                                     |-> cond[4] == (input_raw_value[4] ^ input_invert[4]))
    else $error("Input five not inverted raw level.");
  AST_INPUT5_LEVEL: assert property (input_image[20] == cond[4])
    else $error("Input five level bit misplaced.");
  AST_INPUT6_LEVEL: assert property (input_image[21] == cond[5])
    else $error("Input six level bit misplaced.");
  AST_TICK_BOUND: assert property (tick_cnt <= 17'(`DIOC_SAMPLE_CYCLES - 1))
    else $error("Sample counter beyond its period.");

  COV_SPECIAL: cover property (input_special_enable[0] && limit_negative);
  COV_READ: cover property (avs_read && !avs_waitrequest);
  COV_WRITE: cover property (avs_write && !avs_waitrequest);
  COV_TICK: cover property (tick && next_raw != input_raw_value);
  COV_STEP: cover property (step_mode && step_clock);

endmodule
`default_nettype wire

// ===== hw/dioc_regs.svh
// Register offsets, reset values and timing constants of the digital I/O block.
`ifndef DIOC_REGS_SVH
`define DIOC_REGS_SVH
`define DIOC_OFF_ALT_MASK     4'h0
`define DIOC_OFF_DIR_MASK     4'h1
`define DIOC_OFF_PULL_MASK    4'h2
`define DIOC_OFF_IN_IMAGE     4'h3
`define DIOC_OFF_OUT_IMAGE    4'h4
`define DIOC_OFF_SPEC_EN      4'h5
`define DIOC_OFF_INVERT       4'h6
`define DIOC_OFF_FORCE_EN     4'h7
`define DIOC_OFF_FORCE_VAL    4'h8
`define DIOC_OFF_RAW          4'h9
`define DIOC_OFF_MODE         4'ha
`define DIOC_RST_ZERO32       32'h0000_0000
`define DIOC_RST_ZERO16       16'h0000
`define DIOC_LEVEL_BASE       16
`define DIOC_ALT_CLK_BIT      1
`define DIOC_ALT_DIR_BIT      2
`define DIOC_NUM_PINS         6
`define DIOC_NUM_FLEX         4
`define DIOC_SAMPLE_NS        1000000
`define DIOC_CLK_NS           10
`define DIOC_SAMPLE_CYCLES    (`DIOC_SAMPLE_NS / `DIOC_CLK_NS)
`endif

// ===== hw/dioc_pkg.sv
// Types shared by the digital I/O block.
package dioc_pkg;
  typedef enum logic [0:0] {
    DIOC_BUS_IDLE,
    DIOC_BUS_ANSWER
  } dioc_bus_e;
  typedef logic [5:0] dioc_pins_t;
endpackage

// ===== tb/dioc_pin_model.sv
// Model of the switches and signal sources wired to the six digital I/O pins.
`timescale 1ns/100ps
`default_nettype none
module dioc_pin_model
  import dioc_pkg::*;
(
  // Drive from the block on the four flexible pins, pull selection on all six.
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [5:0] pin_pull_up,
  // Switch levels and whether each switch is closed onto its pin.
  input  wire logic [5:0] ext_drive,
  input  wire logic [5:0] ext_en,
  // Resolved pin levels seen by the block.
  output logic      [5:0] pin_in
);
  // A pin follows the block where it drives, else a switch, else its pull level.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (i < 4 && pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_drive[i];
      end else begin
        pin_in[i] = pin_pull_up[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_digital_io_config_input_conditioning.sv
// Self-checking bench for the digital I/O configuration and input conditioning block.
`timescale 1ns/100ps
`default_nettype none
`include "dioc_regs.svh"
module test_digital_io_config_input_conditioning;
  import dioc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [5:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [5:0]  pin_pull_up;
  logic        step_clock;
  logic        step_direction;
  logic        limit_negative;
  logic        limit_positive;
  logic        home_switch;
  logic        interlock_release;
  logic        brake_request;
  logic [5:0]  ext_drive;
  logic [5:0]  ext_en;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  int          n_fail;
  int          check_count;

  // Block under test and the pin-side model.
  dioc_digital_io i_dioc_digital_io (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up), .step_clock(step_clock),
    .step_direction(step_direction), .limit_negative(limit_negative),
    .limit_positive(limit_positive), .home_switch(home_switch),
    .interlock_release(interlock_release), .brake_request(brake_request));
  dioc_pin_model i_dioc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_up(pin_pull_up), .ext_drive(ext_drive), .ext_en(ext_en), .pin_in(pin_in));

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Checks made: %0d, mismatches: %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon-MM transfer, held until waitrequest is seen low.
  task automatic bus(input logic wr_en, input logic [3:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= addr;
    avs_write     <= wr_en;
    avs_read      <= !wr_en;
    avs_writedata <= wdata;
    // Waitrequest and read data are taken at the rising edge, as the design samples them.
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("Bus transfer got no answer at %0t", $time);
      end_sim();
    end
    rdata = avs_readdata;
    rresp = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Reads a register and compares data and response.
  task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0000_0000);
    chk(rdata, exp);
    chk(rresp, 2'h0);
  endtask

  // Main test sequence.
  initial begin
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    ext_drive = 6'h00;
    ext_en = 6'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Every register reads zero after reset and no pin is driven.
    for (int a = 0; a < 11; a++) begin
      rd_chk(a[3:0], 32'h0000_0000);
    end
    chk({pin_oe, pin_pull_up}, 32'h0000_0000);
    bus(1'b0, 4'hb, 32'h0000_0000);
    chk(rresp, 2'h2);
    chk(rdata, 32'h0000_0000);
    $display("Reset and unmapped read test done");
    // Read-write registers other than the mode register keep their values; alt and pull masks are sixteen bits wide, direction mask four.
    for (int a = 0; a < 9; a++) begin
      if (a != 3) begin
        bus(1'b1, a[3:0], 32'h5a5a_a5c3);
        rd_chk(a[3:0], (a == 1) ? 32'h0000_0003 : (a < 3) ? 32'h0000_a5c3 : 32'h5a5a_a5c3);
        bus(1'b1, a[3:0], 32'h0000_0000);
      end
    end
    bus(1'b1, `DIOC_OFF_RAW, 32'hffff_ffff);
    chk(rresp, 2'h0);
    bus(1'b1, `DIOC_OFF_IN_IMAGE, 32'hffff_ffff);
    rd_chk(`DIOC_OFF_RAW, 32'h0000_0000);
    rd_chk(`DIOC_OFF_IN_IMAGE, 32'h0000_0000);
    $display("Register access test done");
    // Outputs on pins 1 and 4 only, pulls only on inputs, outputs read back.
    bus(1'b1, `DIOC_OFF_DIR_MASK, 32'h0000_000f);
    bus(1'b1, `DIOC_OFF_PULL_MASK, 32'h0000_003f);
    bus(1'b1, `DIOC_OFF_OUT_IMAGE, 32'h000f_0001);
    chk({pin_oe, pin_out}, 32'h0000_0099);
    chk(pin_pull_up, 6'h30);
    chk(brake_request, 1'b1);
    rd_chk(`DIOC_OFF_IN_IMAGE, 32'h0009_0000);
    $display("Direction and pull test done");
    // Stepping mode takes pins 2 and 3 and rewrites the pin configuration.
    bus(1'b1, `DIOC_OFF_MODE, 32'h0000_0001);
    rd_chk(`DIOC_OFF_ALT_MASK, 32'h0000_0006);
    rd_chk(`DIOC_OFF_DIR_MASK, 32'h0000_0009);
    bus(1'b1, `DIOC_OFF_MODE, 32'h0000_0000);
    bus(1'b1, `DIOC_OFF_ALT_MASK, 32'h0000_0000);
    bus(1'b1, `DIOC_OFF_DIR_MASK, 32'h0000_0000);
    bus(1'b1, `DIOC_OFF_PULL_MASK, 32'h0000_0000);
    bus(1'b1, `DIOC_OFF_OUT_IMAGE, 32'h0000_0000);
    $display("Stepping mode test done");
    // Forced values, then inversion, then the special-function gate.
    bus(1'b1, `DIOC_OFF_FORCE_EN, 32'h0000_003f);
    bus(1'b1, `DIOC_OFF_FORCE_VAL, 32'h0000_0005);
    bus(1'b1, `DIOC_OFF_INVERT, 32'h0000_0003);
    bus(1'b1, `DIOC_OFF_SPEC_EN, 32'h0000_000f);
    rd_chk(`DIOC_OFF_IN_IMAGE, 32'h0006_0006);
    chk({limit_negative, limit_positive, home_switch, interlock_release}, 4'h6);
    rd_chk(`DIOC_OFF_RAW, 32'h0000_0000);
    bus(1'b1, `DIOC_OFF_SPEC_EN, 32'h0000_0000);
    rd_chk(`DIOC_OFF_IN_IMAGE, 32'h0006_0000);
    bus(1'b1, `DIOC_OFF_SPEC_EN, 32'h0000_000f);
    bus(1'b1, `DIOC_OFF_INVERT, 32'h0000_0000);
    bus(1'b1, `DIOC_OFF_FORCE_VAL, 32'h0000_003f);
    chk({limit_negative, limit_positive, home_switch, interlock_release}, 4'hf);
    bus(1'b1, `DIOC_OFF_FORCE_VAL, 32'h0000_0004);
    bus(1'b1, `DIOC_OFF_INVERT, 32'h0000_0006);
    bus(1'b1, `DIOC_OFF_ALT_MASK, 32'h0000_0006);
    chk({step_clock, step_direction}, 2'h1);
    $display("Input conditioning test done");
    // A pulse far shorter than a sampling period never reaches the raw value.
    bus(1'b1, `DIOC_OFF_FORCE_EN, 32'h0000_0000);
    @(posedge clk);
    ext_drive <= 6'h3f;
    ext_en <= 6'h3f;
    repeat (50) @(posedge clk);
    ext_en <= 6'h00;
    rd_chk(`DIOC_OFF_RAW, 32'h0000_0000);
    $display("Short pulse test done");
    end_sim();
  end
endmodule
`default_nettype wire
